// ---- inc/scp_params.svh ----
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
// register addresses
`define SCP_A_WDOG      5'h00
`define SCP_A_CR0       5'h01
`define SCP_A_CR1       5'h02
`define SCP_A_CR2       5'h03
`define SCP_A_SR_HI     3'h1
`define SCP_A_CR3       5'h08
// field positions
`define SCP_CMD_BIT     7
`define SCP_WATCHDOG_ENABLE_BIT_BIT    7
`define SCP_WDT_HI      6
`define SCP_WDT_LO      3
`define SCP_MOTEN_BIT   7
`define SCP_SLP_BIT     6
// reset values
`define SCP_CTL_RST     8'h00
// timing
`define SCP_CLK_NS      5
`define SCP_MS_NS       1000000
`define SCP_WD_STEP_MS  32
`define SCP_WD_EARLY_MS 4
`define SCP_CLR_MIN_NS  10000
`define SCP_HOST_RST_MS 2
`define SCP_FRAME_BITS  16
`endif

// ---- inc/scp_pkg.sv ----
`include "scp_params.svh"
package scp_pkg;
   // analog fault inputs
   typedef struct packed {
      logic       tw;
      logic       thermal_shutdown_flag;
      logic       cp_fail;
      logic       open_x;
      logic       open_y;
      logic [3:0] ovc_x;
      logic [3:0] ovc_y;
   } scp_flags_t;

   // control registers
   typedef struct packed {
      logic [7:0] wdog;
      logic [7:0] cr0;
      logic [7:0] cr1;
      logic [7:0] cr2;
      logic [7:0] cr3;
   } scp_ctl_t;

   typedef enum logic [1:0] {
      SCP_WD_OFF  = 2'b00,
      SCP_WD_RUN  = 2'b01,
      SCP_WD_TRIP = 2'b10
   } scp_wd_t;

   // link state, rising edge
   typedef struct packed {
      logic [6:0] sh;
      logic [4:0] bits;
      logic       over;
      logic       exp_data;
      logic [4:0] addr;
      logic       f_wr;
      logic [4:0] f_addr;
      logic [7:0] f_data;
      logic [3:0] rd_st;
      logic       tog;
   } scp_rise_t;

   // system clock state
   typedef struct packed {
      logic [2:0]  cs_s;
      logic [1:0]  hr_s;
      scp_flags_t  f_s1;
      scp_flags_t  f_s2;
      scp_flags_t  lat;
      logic        warm;
      logic        err_n;
      logic        drv;
      logic        tog_seen;
      scp_ctl_t    ctl;
      scp_wd_t     wd;
      logic [23:0] hr_cnt;
      logic [23:0] pre;
      logic [9:0]  ms;
      logic [9:0]  rst_ms;
   } scp_sys_t;
endpackage

// ---- verilog/scp_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"

module scp_ctrl
   import scp_pkg::*;
#(
   parameter int MS_CYC     = `SCP_MS_NS / `SCP_CLK_NS,
   parameter int HR_MIN_CYC = (`SCP_CLR_MIN_NS + `SCP_CLK_NS - 1)
                              / `SCP_CLK_NS,
   parameter int EARLY_MS   = `SCP_WD_EARLY_MS,
   parameter int HOST_MS    = `SCP_HOST_RST_MS
)(
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       spi_clk_i,
   input  wire logic       cs_n_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   output logic            miso_oe_o,
   input  wire logic       hard_reset_input_i,
   input  wire scp_flags_t flags_i,
   output logic            host_reset_output_o,
   output logic            host_reset_oe_o,
   output logic            error_output_n_o,
   output scp_ctl_t        ctl_o,
   output logic            sleep_o,
   output logic            drivers_on_o
);

   // ----------------------------------------------------------
   // link side, rising edge: receive
   // ----------------------------------------------------------
   scp_rise_t  r_q;
   scp_rise_t  r_d;
   logic       fresh_q;
   scp_sys_t   s_q;
   scp_sys_t   s_d;

   // set while deselected, dropped by first edge of a frame
   always_ff @(posedge spi_clk_i or posedge cs_n_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         fresh_q <= 1'b1;
      else if (cs_n_i)
         fresh_q <= 1'b1;
      else
         fresh_q <= 1'b0;
   end

   always_comb
   begin
      scp_rise_t  b;
      logic [7:0] rx;
      b = r_q;
      rx = 8'h00;
      if (fresh_q)
      begin
         b.bits = 5'h00;
         b.over = 1'b0;
         b.exp_data = 1'b0;
         b.rd_st = 4'h0;
         b.f_wr = 1'b0;
         b.tog = ~r_q.tog;
      end
      r_d = b;
      rx = {b.sh, mosi_i};
      r_d.sh = rx[6:0];
      r_d.bits = b.bits + 5'h01;
      if (b.bits == 5'(`SCP_FRAME_BITS))
         r_d.over = 1'b1;
      if (r_d.bits[2:0] == 3'h0)
      begin
         if (b.exp_data)
         begin
            r_d.exp_data = 1'b0;
            if (r_d.bits == 5'(`SCP_FRAME_BITS) && !b.over)
               r_d.f_data = rx;
         end
         else
         begin
            // every non-data byte is a command
            r_d.addr = rx[4:0];
            r_d.exp_data = rx[`SCP_CMD_BIT];
            if (r_d.bits == 5'h08 && !b.over)
            begin
               r_d.f_wr = rx[`SCP_CMD_BIT];
               r_d.f_addr = rx[4:0];
            end
            if (!rx[`SCP_CMD_BIT] && rx[4:2] == `SCP_A_SR_HI)
               r_d.rd_st[rx[1:0]] = 1'b1;
         end
      end
   end

   always_ff @(posedge spi_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   // ----------------------------------------------------------
   // register read view
   // ----------------------------------------------------------
   function automatic logic [7:0] par7(input logic [6:0] v);
      par7 = {^v, v};
   endfunction

   function automatic logic [7:0] rd_val(input logic [4:0] a,
                                         input scp_sys_t  s);
      logic [7:0] v;
      v = 8'h00;
      if (a == `SCP_A_WDOG)
         v = s.ctl.wdog;
      else if (a == `SCP_A_CR0)
         v = s.ctl.cr0;
      else if (a == `SCP_A_CR1)
         v = s.ctl.cr1;
      else if (a == `SCP_A_CR2)
         v = s.ctl.cr2;
      else if (a == `SCP_A_CR3)
         v = s.ctl.cr3;
      else if (a == {`SCP_A_SR_HI, 2'h0})
         v = par7({s.lat.tw, s.lat.cp_fail, s.warm, s.lat.open_x,
                   s.lat.open_y, 2'h0});
      else if (a == {`SCP_A_SR_HI, 2'h1})
         v = par7({s.lat.ovc_x, 3'h0});
      else if (a == {`SCP_A_SR_HI, 2'h2})
         v = par7({s.lat.thermal_shutdown_flag, s.lat.ovc_y, 2'h0});
      else if (a == {`SCP_A_SR_HI, 2'h3})
         v = par7(7'h00);
      rd_val = v;
   endfunction

   // ----------------------------------------------------------
   // link side, falling edge: transmit
   // ----------------------------------------------------------
   logic [7:0] osh_q;
   logic [7:0] osh_d;

   always_comb
   begin
      // byte boundary reloads from last address
      if (r_q.bits[2:0] == 3'h0 && r_q.bits != 5'h00)
         osh_d = rd_val(r_q.addr, s_q);
      else
         osh_d = {osh_q[6:0], 1'b0};
   end

   // first byte after power-up shifts stale zeros
   always_ff @(negedge spi_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         osh_q <= 8'h00;
      else
         osh_q <= osh_d;
   end

   assign miso_o = osh_q[7];

   // released at once when deselected
   always_ff @(negedge spi_clk_i or posedge cs_n_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         miso_oe_o <= 1'b0;
      else if (cs_n_i)
         miso_oe_o <= 1'b0;
      else
         miso_oe_o <= 1'b1;
   end

   // ----------------------------------------------------------
   // system side
   // ----------------------------------------------------------
   logic       cs_rise;
   logic       cs_high;
   logic       new_frame;
   logic       wr_ok;
   logic       sleep;
   logic       hr_act;
   logic       tick;
   logic [9:0] to_ms;
   logic [3:0] rd_clr;

   always_comb
   begin
      s_d = s_q;
      s_d.cs_s = {s_q.cs_s[1], s_q.cs_s[1], s_q.cs_s[0]};
      s_d.cs_s[0] = cs_n_i;
      s_d.cs_s[2] = s_q.cs_s[1];
      s_d.cs_s[1] = s_q.cs_s[0];
      s_d.hr_s = {s_q.hr_s[0], hard_reset_input_i};
      s_d.f_s1 = flags_i;
      s_d.f_s2 = s_q.f_s1;
      cs_high = s_q.cs_s[1];
      cs_rise = s_q.cs_s[1] && !s_q.cs_s[2];
      new_frame = cs_rise && (r_q.tog != s_q.tog_seen);
      if (cs_rise)
         s_d.tog_seen = r_q.tog;
      wr_ok = new_frame && r_q.f_wr && !r_q.over &&
              r_q.bits == 5'(`SCP_FRAME_BITS);
      rd_clr = new_frame ? r_q.rd_st : 4'h0;
      sleep = s_q.ctl.cr2[`SCP_SLP_BIT];

      // --- control register commit
      if (wr_ok)
      begin
         // status addresses fall through untouched
         if (r_q.f_addr == `SCP_A_WDOG)
            s_d.ctl.wdog = r_q.f_data;
         else if (r_q.f_addr == `SCP_A_CR0)
            s_d.ctl.cr0 = r_q.f_data;
         else if (r_q.f_addr == `SCP_A_CR1)
            s_d.ctl.cr1 = r_q.f_data;
         else if (r_q.f_addr == `SCP_A_CR2)
            s_d.ctl.cr2 = r_q.f_data;
         else if (r_q.f_addr == `SCP_A_CR3)
            s_d.ctl.cr3 = r_q.f_data;
      end

      // status latch, only while deselected
      if (cs_high)
      begin
         if (rd_clr[0])
         begin
            s_d.lat.tw = 1'b0;
            s_d.lat.cp_fail = 1'b0;
            s_d.lat.open_x = 1'b0;
            s_d.lat.open_y = 1'b0;
            s_d.warm = 1'b0;
         end
         if (rd_clr[1])
            s_d.lat.ovc_x = 4'h0;
         if (rd_clr[2])
         begin
            s_d.lat.thermal_shutdown_flag = 1'b0;
            s_d.lat.ovc_y = 4'h0;
         end
         // new faults win over a same-cycle clear
         s_d.lat = s_d.lat | s_q.f_s2;
         s_d.err_n = ~(|s_d.lat);
      end

      // watchdog
      tick = 1'b0;
      to_ms = 10'((({6'h00, s_q.ctl.wdog[`SCP_WDT_HI:`SCP_WDT_LO]})
              + 10'h001) * `SCP_WD_STEP_MS);
      if (!sleep)
      begin
         if (s_q.pre >= 24'(MS_CYC - 1))
         begin
            s_d.pre = 24'h000000;
            tick = 1'b1;
         end
         else
            s_d.pre = s_q.pre + 24'h000001;
      end
      // frozen while asleep
      if (tick && s_q.ms != 10'h3ff)
         s_d.ms = s_q.ms + 10'h001;
      case (s_q.wd)
         SCP_WD_OFF:
         begin
            if (wr_ok && r_q.f_addr == `SCP_A_WDOG &&
                r_q.f_data[`SCP_WATCHDOG_ENABLE_BIT_BIT])
            begin
               s_d.wd = SCP_WD_RUN;
               s_d.ms = 10'h000;
               s_d.pre = 24'h000000;
            end
         end
         SCP_WD_RUN:
         begin
            if (wr_ok && r_q.f_addr == `SCP_A_WDOG)
            begin
               if (!r_q.f_data[`SCP_WATCHDOG_ENABLE_BIT_BIT])
                  s_d.wd = SCP_WD_OFF;
               else if (s_q.ms < 10'(EARLY_MS))
                  s_d.wd = SCP_WD_TRIP;
               else
               begin
                  s_d.ms = 10'h000;
                  s_d.pre = 24'h000000;
               end
            end
            else if (s_q.ms >= to_ms)
               s_d.wd = SCP_WD_TRIP;
            if (s_d.wd == SCP_WD_TRIP)
            begin
               s_d.warm = 1'b1;
               s_d.rst_ms = 10'h000;
               s_d.pre = 24'h000000;
            end
         end
         SCP_WD_TRIP:
         begin
            s_d.warm = 1'b1;
            if (tick)
               s_d.rst_ms = s_q.rst_ms + 10'h001;
            if (s_q.rst_ms >= 10'(HOST_MS))
            begin
               s_d.wd = SCP_WD_RUN;
               s_d.ms = 10'h000;
            end
         end
         default:
            s_d.wd = SCP_WD_OFF;
      endcase

      // hard reset
      if (!s_q.hr_s[1])
         s_d.hr_cnt = 24'h000000;
      else if (s_q.hr_cnt < 24'(HR_MIN_CYC))
         s_d.hr_cnt = s_q.hr_cnt + 24'h000001;
      hr_act = (s_q.hr_cnt >= 24'(HR_MIN_CYC)) && !sleep;
      if (hr_act)
      begin
         s_d.ctl = {5{`SCP_CTL_RST}};
         s_d.lat = '0;
         s_d.err_n = 1'b1;
         s_d.warm = 1'b0;
         // watchdog cleared, host reset stays off
         s_d.wd = SCP_WD_OFF;
         s_d.ms = 10'h000;
         s_d.pre = 24'h000000;
         s_d.rst_ms = 10'h000;
      end

      // drivers high impedance while asleep
      s_d.drv = s_d.ctl.cr2[`SCP_MOTEN_BIT] &&
                !s_d.ctl.cr2[`SCP_SLP_BIT];
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s_q <= '0;
         s_q.cs_s <= 3'h7;
         s_q.err_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   logic rst_oe_q;

   // open drain, low only while tripped
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rst_oe_q <= 1'b0;
      else
         rst_oe_q <= (s_d.wd == SCP_WD_TRIP);
   end

   assign host_reset_oe_o     = rst_oe_q;
   assign host_reset_output_o = 1'b0;
   assign error_output_n_o    = s_q.err_n;
   assign ctl_o               = s_q.ctl;
   assign sleep_o             = s_q.ctl.cr2[`SCP_SLP_BIT];
   assign drivers_on_o        = s_q.drv;

endmodule
`default_nettype wire

// ---- tb/scp_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module scp_ctrl_chk
   import scp_pkg::*;
#(
   parameter int MS_CYC     = 200,
   parameter int HOST_MS    = 2,
   parameter int HR_MIN_CYC = 4
)(
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       spi_clk_i,
   input wire logic       cs_n_i,
   input wire logic       miso_o,
   input wire logic       miso_oe_o,
   input wire logic       hard_reset_input_i,
   input wire scp_flags_t flags_i,
   input wire logic       host_reset_oe_o,
   input wire logic       error_output_n_o,
   input wire scp_ctl_t   ctl_o,
   input wire logic       sleep_o,
   input wire logic       drivers_on_o
);
   logic [15:0] quiet_q;
   logic [15:0] hr_q;
   logic [15:0] host_q;
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         quiet_q <= '0;
         hr_q    <= '0;
         host_q  <= '0;
      end
      else
      begin
         quiet_q <= (!cs_n_i && !hard_reset_input_i) ? quiet_q + 16'h1 : '0;
         hr_q    <= hard_reset_input_i ? hr_q + 16'h1 : '0;
         host_q  <= host_reset_oe_o ? host_q + 16'h1 : '0;
      end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_oe_cs; cs_n_i |-> !miso_oe_o; endproperty
   property p_miso_fall;
      miso_oe_o && $changed(miso_o) |-> !spi_clk_i;
   endproperty
   property p_ctl_quiet; quiet_q > 16'h5 |-> $stable(ctl_o); endproperty
   property p_err_quiet;
      quiet_q > 16'h5 |-> $stable(error_output_n_o);
   endproperty
   property p_err_flag;
      (cs_n_i && !hard_reset_input_i && flags_i.tw)[*6]
         |-> !error_output_n_o;
   endproperty
   property p_hr_clear;
      hr_q > HR_MIN_CYC + 4 && !sleep_o |-> ctl_o == '0 && !host_reset_oe_o;
   endproperty
   property p_host_max; host_q <= (HOST_MS + 1) * MS_CYC + 2; endproperty
   property p_host_min;
      $fell(host_reset_oe_o) |-> host_q >= HOST_MS * MS_CYC - 1;
   endproperty
   property p_sleep_drv;
      sleep_o && $past(sleep_o) |-> !drivers_on_o;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("miso driven while deselected");
   a_miso_fall: assert property (p_miso_fall)
      else $error("miso changed while serial clock high");
   a_ctl_quiet: assert property (p_ctl_quiet)
      else $error("control changed inside a frame");
   a_err_quiet: assert property (p_err_quiet)
      else $error("error output changed inside a frame");
   a_err_flag: assert property (p_err_flag)
      else $error("error output not low on warning");
   a_hr_clear: assert property (p_hr_clear)
      else $error("hard reset did not clear");
   a_host_max: assert property (p_host_max)
      else $error("host reset too long");
   a_host_min: assert property (p_host_min)
      else $error("host reset too short");
   a_sleep_drv: assert property (p_sleep_drv)
      else $error("drivers on in sleep");
   c_host: cover property ($rose(host_reset_oe_o));
   c_err: cover property ($fell(error_output_n_o));
   c_sleep: cover property ($rose(sleep_o));
endmodule
`default_nettype wire

// ---- tb/scp_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// mode 0 serial master
// ----
module scp_master (
   output logic           spi_clk_o,
   output logic           cs_n_o,
   output logic           mosi_o,
   input  wire logic      miso_i
);
   initial
   begin
      spi_clk_o = 1'b0;
      cs_n_o    = 1'b1;
      mosi_o    = 1'b1;
   end
   // only the master starts frames; clock still outside them
   task automatic xfer(input int n, input logic [23:0] tx,
                       output logic [23:0] rx);
      rx = '0;
      #1;
      cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi_o = tx[i];
         #40 spi_clk_o = 1'b1;
         rx = {rx[22:0], miso_i};
         #40 spi_clk_o = 1'b0;
      end
      #40 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #100;
   endtask
endmodule
`default_nettype wire

// ---- tb/scp_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module scp_ctrl_bench;
   import scp_pkg::*;
   localparam int MS = 200;
   logic       clk_i = 1'b0;
   logic       rst_b_i;
   logic       hard_reset_input_i;
   scp_flags_t flags_i;
   wire logic  spi_clk, cs_n, mosi, miso_w;
   logic       miso, miso_oe, host_oe, err_n, sleep, drv, host_lvl;
   scp_ctl_t   ctl;
   int         num_errors = 0;
   int         num_checks = 0;
   always #2.5 clk_i = ~clk_i;
   assign miso_w = miso_oe ? miso : 1'b1;
   scp_master mst (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi),
                   .miso_i(miso_w));
   scp_ctrl #(.MS_CYC(MS), .HR_MIN_CYC(4), .EARLY_MS(2), .HOST_MS(2)) dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_clk_i(spi_clk),
      .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
      .hard_reset_input_i(hard_reset_input_i), .flags_i(flags_i),
      .host_reset_output_o(host_lvl), .host_reset_oe_o(host_oe),
      .error_output_n_o(err_n), .ctl_o(ctl), .sleep_o(sleep),
      .drivers_on_o(drv));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [39:0] s, e);
      num_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [23:0] rx;
      mst.xfer(16, {8'h0, 3'h4, a, d}, rx);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      logic [23:0] rx;
      mst.xfer(16, {8'h0, 3'h0, a, 8'h00}, rx);
      chk("read", rx[7:0], e);
   endtask
   task automatic hard_pulse;
      @(posedge clk_i);
      hard_reset_input_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      hard_reset_input_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   // waits for host reset, then its end, then stops the timer
   task automatic wd_trip(input int lo, input int hi);
      int n;
      n = 0;
      while (host_oe !== 1'b1 && n < hi + 50)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("wd_time", 40'(n >= lo && n <= hi), 40'h1);
      chk("host_lvl", host_lvl, 1'b0);
      if (n > hi)
         finish_test();
      n = 0;
      while (host_oe === 1'b1 && n < 4 * MS)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("host_end", 40'(n < 4 * MS), 40'h1);
      if (n >= 4 * MS)
         finish_test();
      wr(5'h00, 8'h00);
   endtask
   initial
   begin
      logic [23:0] rx;
      rst_b_i = 1'b1;
      hard_reset_input_i = 1'b0;
      flags_i = '0;
      #1 rst_b_i = 1'b0;
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("ctl", ctl, '0);
      chk("err_n", err_n, 1'b1);
      chk("host_oe", host_oe, 1'b0);
      $display("test reset done");
      wr(5'h01, 8'h3c);
      wr(5'h02, 8'ha5);
      wr(5'h08, 8'h5a);
      chk("ctl", ctl, 40'h003ca5005a);
      mst.xfer(24, 24'h010208, rx);
      chk("chain", rx[15:0], 16'h3ca5);
      rd(5'h08, 8'h5a);
      mst.xfer(15, 24'h4108, rx);
      mst.xfer(17, 24'h10422, rx);
      wr(5'h04, 8'hff);
      wr(5'h1f, 8'hff);
      mst.xfer(16, 24'h0211, rx);
      chk("ctl", ctl, 40'h003ca5005a);
      $display("test link done");
      @(posedge clk_i);
      flags_i.tw <= 1'b1;
      flags_i.ovc_x <= 4'hb;
      repeat (10) @(posedge clk_i);
      chk("err_n", err_n, 1'b0);
      flags_i <= '0;
      rd(5'h04, 8'hc0);
      rd(5'h05, 8'hd8);
      chk("err_n", err_n, 1'b1);
      rd(5'h04, 8'h00);
      $display("test status done");
      wr(5'h00, 8'h80);
      repeat (3000) @(posedge clk_i);
      wr(5'h00, 8'h80);
      wd_trip(31 * MS, 33 * MS);
      rd(5'h04, 8'h90);
      wr(5'h00, 8'h88);
      wd_trip(63 * MS, 65 * MS);
      wr(5'h00, 8'h80);
      wr(5'h00, 8'h80);
      wd_trip(0, 50);
      rd(5'h04, 8'h90);
      $display("test watchdog done");
      hard_pulse();
      chk("ctl", ctl, '0);
      chk("host_oe", host_oe, 1'b0);
      wr(5'h03, 8'hc0);
      chk("sleep", {sleep, drv}, 2'b10);
      hard_pulse();
      chk("cr2", ctl.cr2, 8'hc0);
      wr(5'h03, 8'h80);
      chk("sleep", {sleep, drv}, 2'b01);
      $display("test reset and sleep done");
      wr(5'h00, 8'h80);
      repeat (3000) @(posedge clk_i);
      wr(5'h03, 8'hc0);
      repeat (6000) @(posedge clk_i);
      wr(5'h03, 8'h80);
      wd_trip(14 * MS, 17 * MS);
      $display("test sleep freeze done");
      finish_test();
   end
endmodule
bind scp_ctrl scp_ctrl_chk #(.MS_CYC(MS_CYC), .HOST_MS(HOST_MS),
   .HR_MIN_CYC(HR_MIN_CYC)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .spi_clk_i(spi_clk_i), .cs_n_i(cs_n_i), .miso_o(miso_o),
   .miso_oe_o(miso_oe_o), .hard_reset_input_i(hard_reset_input_i),
   .flags_i(flags_i), .host_reset_oe_o(host_reset_oe_o),
   .error_output_n_o(error_output_n_o), .ctl_o(ctl_o),
   .sleep_o(sleep_o), .drivers_on_o(drivers_on_o));
`default_nettype wire
